// >>> acr_pkg.sv
// package: acquisition control register layout and shared carrier types
package acr_pkg;
   localparam logic [4:0] ACR_OFFSET = 5'h00;
   localparam int ACR_WIDTH = 16;
   localparam int BIT_MEM_SEL = 15;
   localparam int BIT_SERIAL_BIT_OUT = 14;
   localparam int BIT_SCLK = 13;
   localparam int BIT_SCAN_DIV = 12;
   localparam int BIT_RSVD11 = 11;
   localparam int BIT_INHIBIT = 10;
   localparam int BIT_RETRIG_BLK = 9;
   localparam int BIT_ACQ_EN = 8;
   localparam int BIT_SCAN = 7;
   localparam int BIT_INTERVAL = 6;
   localparam int BIT_LONG = 5;
   localparam int BIT_SYNC_TRIG = 4;
   // no reset value is documented; reset leaves the register alone
   localparam logic [15:0] ACR_WRITE_MASK = 16'hf7f0;
   localparam int CAL_DAC_BITS = 8;

   typedef struct packed {
      logic serial_memory_select;
      logic serial_bit_out;
      logic serial_clock;
      logic scan_sequence_divide;
      logic conversion_inhibit;
      logic retrigger_block;
      logic acquisition_enable;
      logic multi_channel_scan;
      logic interval_scan_select;
      logic long_count_select;
      logic sync_bus_trigger_enable;
   } acr_ctrl_type;

   typedef struct packed {
      logic software_start;
      logic external_trigger_n;
      logic sync_bus_trigger;
      logic acquisition_done;
      logic progress_clear;
   } acr_trig_type;
endpackage

// >>> acr_cal_dac.sv
// calibration dac: shifts serial data on each clock with shift_en set, loads on strobe
`timescale 1ns/1ps
module acr_cal_dac #(
   parameter int BITS = acr_pkg::CAL_DAC_BITS
)(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic shift_en,
   input wire logic serial_in,
   input wire logic load,
   output logic [BITS-1:0] value
);
   typedef struct packed {
      logic [BITS-1:0] shift;
      logic [BITS-1:0] out;
   } acr_dac_state_type;
   acr_dac_state_type s_q, s_d;

   always_comb
   begin
      s_d = s_q;
      if (shift_en)
      begin
         s_d.shift = {s_q.shift[BITS-2:0], serial_in}; // R5
      end
      if (load)
      begin
         s_d.out = s_q.shift; // R7
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign value = s_q.out;

   AST_DAC_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
      !$past(load) |-> $stable(value)) else $error("dac output moved without load"); // R7
endmodule

// >>> acr_trig_gate.sv
// trigger qualification: source select, enable and retrigger blocking
`timescale 1ns/1ps
module acr_trig_gate (
   input wire logic clk_sys,
   input wire logic reset,
   input acr_pkg::acr_ctrl_type ctrl,
   input acr_pkg::acr_trig_type trig,
   output logic start_counters,
   output logic in_progress
);
   typedef struct packed {
      logic ext_n_prev;
      logic running;
      logic progress;
      logic start;
   } acr_gate_state_type;
   acr_gate_state_type s_q, s_d;
   logic ext_fall;
   logic request;
   logic idle;

   always_comb
   begin
      s_d = s_q;
      ext_fall = s_q.ext_n_prev && !trig.external_trigger_n;
      if (ctrl.sync_bus_trigger_enable)
      begin
         request = trig.sync_bus_trigger; // R21
      end
      else
      begin
         request = trig.software_start || ext_fall; // R21
      end
      // blocked mode waits for software acknowledge, open mode only for the run end
      idle = !s_q.running && !(ctrl.retrigger_block && s_q.progress); // R11 R12
      s_d.ext_n_prev = trig.external_trigger_n;
      s_d.start = ctrl.acquisition_enable && request && idle; // R13
      if (trig.acquisition_done)
      begin
         s_d.running = 1'b0;
      end
      if (trig.progress_clear)
      begin
         s_d.progress = 1'b0;
      end
      if (s_d.start)
      begin
         s_d.running = 1'b1;
         s_d.progress = 1'b1;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         s_q <= '{ext_n_prev: 1'b1, default: 1'b0};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign start_counters = s_q.start;
   assign in_progress = s_q.progress;

   AST_NO_START_DISABLED: assert property (@(posedge clk_sys) disable iff (reset)
      !ctrl.acquisition_enable |=> !start_counters) else $error("start while disabled"); // R13
   AST_RETRIG_BLOCKED: assert property (@(posedge clk_sys) disable iff (reset)
      (ctrl.retrigger_block && in_progress) |=> !start_counters)
      else $error("retrigger while blocked"); // R11
endmodule

// >>> acr_top.sv
// acquisition control register: write-only word at offset 0 and its effects
//
// Contract
// R1 - write-only 16-bit register at offset 0, not cleared by reset.
// R2 - bit 15 drives the calibration memory chip select.
// R3 - software pulses serial clock once before raising memory select.
// R4 - bit 14 drives the shared serial data line.
// R5 - rising serial clock shifts data into dacs, and memory when selected.
// R6 - without memory select, serial clock leaves the memory untouched.
// R7 - dacs always shift but outputs change only on load strobe.
// R8 - bit 12 steps sequencing by counter 1, else after every conversion.
// R9 - software writes zero to reserved bit 11.
// R10 - bit 10 set blocks all conversions.
// R11 - retrigger block ignores triggers until progress flag cleared.
// R12 - without block, triggers accepted any time after run ends.
// R13 - acquisition enable lets start strobe or trigger start counters.
// R14 - scan bit with enable alternates channels per configuration memory.
// R15 - scan clock output enabled only while scan bit set.
// R16 - interval scan runs one sequence per scan interval.
// R17 - continuous scan repeats sequences back to back.
// R18 - long count clear uses counter 4 alone, 16-bit.
// R19 - long count set cascades counter 4 into counter 5.
// R20 - software picks 32-bit mode at 65,537 conversions or more.
// R21 - bit 4 takes triggers only from sync bus, else start or falling trigger.
// R22 - software writes zero to reserved bits 3 to 0.
// R23 - all fields captured together on one word write.
`timescale 1ns/1ps
module acr_top #(
   parameter int DAC_BITS = acr_pkg::CAL_DAC_BITS
)(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [4:0] io_addr,
   input wire logic io_write,
   input wire logic io_word,
   input wire logic [15:0] io_wdata,
   input wire logic software_start,
   input wire logic external_trigger_n,
   input wire logic sync_bus_trigger,
   input wire logic acquisition_done,
   input wire logic progress_clear,
   input wire logic conversion_tick,
   input wire logic counter1_out,
   input wire logic scan_interval_tick,
   input wire logic sequence_end,
   input wire logic cal_dac0_load,
   input wire logic cal_dac1_load,
   output logic serial_memory_select,
   output logic serial_bit_out,
   output logic serial_memory_clock,
   output logic [DAC_BITS-1:0] cal_dac0_value,
   output logic [DAC_BITS-1:0] cal_dac1_value,
   output logic conversion_allow,
   output logic acquisition_start,
   output logic acquisition_in_progress,
   output logic config_mem_advance,
   output logic scan_active,
   output logic scan_sequence_go,
   output logic scan_clock_out,
   output logic counter_cascade,
   output logic counter5_enable
);
   typedef struct packed {
      acr_pkg::acr_ctrl_type ctrl;
      logic sclk_prev;
      logic mem_clk;
      logic dac_shift;
      logic conv_allow;
      logic advance;
      logic scan_act;
      logic seq_go;
      logic seq_busy;
      logic scan_clk;
      logic cascade;
      logic cnt5_en;
      logic [DAC_BITS-1:0] dac0_q;
      logic [DAC_BITS-1:0] dac1_q;
   } acr_state_type;

   acr_state_type s_q, s_d;
   acr_pkg::acr_trig_type trig;
   logic start_raw;
   logic progress_raw;
   logic [DAC_BITS-1:0] dac0_raw;
   logic [DAC_BITS-1:0] dac1_raw;
   logic reg_write;
   logic sclk_rise;
   logic scanning;

   function automatic acr_pkg::acr_ctrl_type decode_word(input logic [15:0] w);
      acr_pkg::acr_ctrl_type c;
      c.serial_memory_select = w[acr_pkg::BIT_MEM_SEL];
      c.serial_bit_out = w[acr_pkg::BIT_SERIAL_BIT_OUT];
      c.serial_clock = w[acr_pkg::BIT_SCLK];
      c.scan_sequence_divide = w[acr_pkg::BIT_SCAN_DIV];
      c.conversion_inhibit = w[acr_pkg::BIT_INHIBIT];
      c.retrigger_block = w[acr_pkg::BIT_RETRIG_BLK];
      c.acquisition_enable = w[acr_pkg::BIT_ACQ_EN];
      c.multi_channel_scan = w[acr_pkg::BIT_SCAN];
      c.interval_scan_select = w[acr_pkg::BIT_INTERVAL];
      c.long_count_select = w[acr_pkg::BIT_LONG];
      c.sync_bus_trigger_enable = w[acr_pkg::BIT_SYNC_TRIG];
      return c;
   endfunction

   // only a word write at the register's offset is taken; byte writes are invalid
   assign reg_write = io_write && io_word && (io_addr == acr_pkg::ACR_OFFSET); // R1 R23

   assign trig.software_start = software_start;
   assign trig.external_trigger_n = external_trigger_n;
   assign trig.sync_bus_trigger = sync_bus_trigger;
   assign trig.acquisition_done = acquisition_done;
   assign trig.progress_clear = progress_clear;

   acr_trig_gate u_gate (
      .clk_sys(clk_sys),
      .reset(reset),
      .ctrl(s_q.ctrl),
      .trig(trig),
      .start_counters(start_raw),
      .in_progress(progress_raw)
   );

   acr_cal_dac #(.BITS(DAC_BITS)) u_dac0 (
      .clk_sys(clk_sys),
      .reset(reset),
      .shift_en(s_q.dac_shift),
      .serial_in(s_q.ctrl.serial_bit_out),
      .load(cal_dac0_load),
      .value(dac0_raw)
   );

   acr_cal_dac #(.BITS(DAC_BITS)) u_dac1 (
      .clk_sys(clk_sys),
      .reset(reset),
      .shift_en(s_q.dac_shift),
      .serial_in(s_q.ctrl.serial_bit_out),
      .load(cal_dac1_load),
      .value(dac1_raw)
   );

   always_comb
   begin
      s_d = s_q;
      if (reg_write)
      begin
         s_d.ctrl = decode_word(io_wdata & acr_pkg::ACR_WRITE_MASK); // R23
      end
      sclk_rise = s_q.ctrl.serial_clock && !s_q.sclk_prev;
      s_d.sclk_prev = s_q.ctrl.serial_clock;
      s_d.dac_shift = sclk_rise; // R5 R7
      // memory sees the clock only while selected, so it ignores toggles otherwise
      s_d.mem_clk = s_q.ctrl.serial_clock && s_q.ctrl.serial_memory_select; // R5 R6
      s_d.conv_allow = !s_q.ctrl.conversion_inhibit; // R10
      scanning = s_q.ctrl.multi_channel_scan && s_q.ctrl.acquisition_enable;
      s_d.scan_act = scanning; // R14
      s_d.scan_clk = s_q.ctrl.multi_channel_scan && conversion_tick; // R15
      if (s_q.ctrl.scan_sequence_divide)
      begin
         s_d.advance = scanning && counter1_out; // R8
      end
      else
      begin
         s_d.advance = scanning && conversion_tick && !s_q.ctrl.conversion_inhibit; // R8
      end
      s_d.seq_go = 1'b0;
      if (!scanning)
      begin
         s_d.seq_busy = 1'b0;
      end
      else if (s_q.ctrl.interval_scan_select)
      begin
         if (sequence_end)
         begin
            s_d.seq_busy = 1'b0;
         end
         if (scan_interval_tick && !s_q.seq_busy)
         begin
            s_d.seq_go = 1'b1; // R16
            s_d.seq_busy = 1'b1;
         end
      end
      else
      begin
         s_d.seq_go = !s_q.seq_busy || sequence_end; // R17
         s_d.seq_busy = 1'b1;
      end
      s_d.cascade = s_q.ctrl.long_count_select; // R18 R19
      s_d.cnt5_en = s_q.ctrl.long_count_select; // R19
      s_d.dac0_q = dac0_raw;
      s_d.dac1_q = dac1_raw;
   end

   // control word keeps its value through reset; only derived state is cleared
   always_ff @(posedge clk_sys)
   begin
      s_q.ctrl <= s_d.ctrl; // R1
      // the edge detector follows the kept control word, so a reset adds no false rise
      s_q.sclk_prev <= s_d.sclk_prev; // R5
      if (reset)
      begin
         s_q.mem_clk <= 1'b0;
         s_q.dac_shift <= 1'b0;
         s_q.conv_allow <= 1'b0;
         s_q.advance <= 1'b0;
         s_q.scan_act <= 1'b0;
         s_q.seq_go <= 1'b0;
         s_q.seq_busy <= 1'b0;
         s_q.scan_clk <= 1'b0;
         s_q.cascade <= 1'b0;
         s_q.cnt5_en <= 1'b0;
         s_q.dac0_q <= '0;
         s_q.dac1_q <= '0;
      end
      else
      begin
         s_q.mem_clk <= s_d.mem_clk;
         s_q.dac_shift <= s_d.dac_shift;
         s_q.conv_allow <= s_d.conv_allow;
         s_q.advance <= s_d.advance;
         s_q.scan_act <= s_d.scan_act;
         s_q.seq_go <= s_d.seq_go;
         s_q.seq_busy <= s_d.seq_busy;
         s_q.scan_clk <= s_d.scan_clk;
         s_q.cascade <= s_d.cascade;
         s_q.cnt5_en <= s_d.cnt5_en;
         s_q.dac0_q <= s_d.dac0_q;
         s_q.dac1_q <= s_d.dac1_q;
      end
   end

   assign serial_memory_select = s_q.ctrl.serial_memory_select; // R2
   assign serial_bit_out = s_q.ctrl.serial_bit_out; // R4
   assign serial_memory_clock = s_q.mem_clk;
   assign cal_dac0_value = s_q.dac0_q;
   assign cal_dac1_value = s_q.dac1_q;
   assign conversion_allow = s_q.conv_allow;
   assign acquisition_start = start_raw;
   assign acquisition_in_progress = progress_raw;
   assign config_mem_advance = s_q.advance;
   assign scan_active = s_q.scan_act;
   assign scan_sequence_go = s_q.seq_go;
   assign scan_clock_out = s_q.scan_clk;
   assign counter_cascade = s_q.cascade;
   assign counter5_enable = s_q.cnt5_en;

   sequence seq_word_write(logic [15:0] w);
      reg_write && io_wdata == w;
   endsequence

   AST_WRITE_CAPTURE: assert property (@(posedge clk_sys)
      reg_write |=> serial_memory_select == $past(io_wdata[acr_pkg::BIT_MEM_SEL])
      && serial_bit_out == $past(io_wdata[acr_pkg::BIT_SERIAL_BIT_OUT]))
      else $error("serial bits not captured"); // R2
   AST_HOLD_NO_WRITE: assert property (@(posedge clk_sys) disable iff (reset)
      !reg_write |=> $stable(s_q.ctrl)) else $error("control changed without write"); // R23
   AST_MEM_CLOCK_GATED: assert property (@(posedge clk_sys) disable iff (reset)
      !s_q.ctrl.serial_memory_select |=> !serial_memory_clock)
      else $error("memory clocked while deselected"); // R6
   AST_INHIBIT: assert property (@(posedge clk_sys) disable iff (reset)
      s_q.ctrl.conversion_inhibit |=> !conversion_allow) else $error("conversion not inhibited"); // R10
   AST_SCAN_CLOCK: assert property (@(posedge clk_sys) disable iff (reset)
      !s_q.ctrl.multi_channel_scan |=> !scan_clock_out) else $error("scan clock while off"); // R15
   AST_CASCADE: assert property (@(posedge clk_sys) disable iff (reset)
      reg_write ##1 !reg_write |=> counter_cascade == $past(io_wdata[acr_pkg::BIT_LONG], 2))
      else $error("count mode mismatch"); // R19
   AST_SYNC_ONLY: assert property (@(posedge clk_sys) disable iff (reset)
      (s_q.ctrl.sync_bus_trigger_enable && !sync_bus_trigger) |=> !acquisition_start)
      else $error("local trigger used in sync mode"); // R21
   AST_DAC_SHIFT_EDGE: assert property (@(posedge clk_sys) disable iff (reset)
      s_q.dac_shift |-> $past(s_q.ctrl.serial_clock) && !$past(s_q.sclk_prev))
      else $error("dac shift without clock rise"); // R5
   AST_SEQ_DIRECT_ADVANCE: assert property (@(posedge clk_sys) disable iff (reset)
      (!s_q.ctrl.scan_sequence_divide && !scanning) |=> !config_mem_advance)
      else $error("advance while not scanning"); // R8
endmodule

// >>> acr_eeprom_model.sv
// behavioural calibration memory on the serial control lines
`timescale 1ns/1ps
module acr_eeprom_model (
   input wire logic serial_memory_select,
   input wire logic serial_bit_out,
   input wire logic serial_memory_clock,
   output logic [7:0] shift_q,
   output int bit_cnt
);
   initial
   begin
      shift_q = 8'h00;
      bit_cnt = 0;
   end
   // an unselected memory ignores its clock, so a stray edge never counts
   always @(posedge serial_memory_clock)
   begin
      if (serial_memory_select === 1'b1)
      begin
         shift_q <= {shift_q[6:0], serial_bit_out};
         bit_cnt <= bit_cnt + 1;
      end
   end
endmodule

// >>> testbench.sv
// self-checking bench for the acquisition control register
`timescale 1ns/1ps
module testbench;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [4:0] io_addr = 5'h00;
   logic io_write = 1'b0;
   logic io_word = 1'b0;
   logic [15:0] io_wdata = 16'h0000;
   logic external_trigger_n = 1'b1;
   logic [9:0] pl = 10'h000;
   logic [7:0] dac0;
   logic [7:0] dac1;
   logic [7:0] ee_q;
   logic sel, sdo, sck, cav, ast, aip, adv, sact, sgo, sco, casc, c5;
   logic [3:0] obs;
   int ee_cnt;
   int error_cnt = 0;
   int n_tests = 0;
   logic [31:0] seed = 32'h54636a7f;

   always #2 clk_sys = ~clk_sys;
   assign obs = {sco, adv, sgo, ast};

   acr_top u_dut (
      .clk_sys(clk_sys), .reset(reset), .io_addr(io_addr), .io_write(io_write),
      .io_word(io_word), .io_wdata(io_wdata), .software_start(pl[4]),
      .external_trigger_n(external_trigger_n), .sync_bus_trigger(pl[5]),
      .acquisition_done(pl[0]), .progress_clear(pl[1]), .conversion_tick(pl[6]),
      .counter1_out(pl[7]), .scan_interval_tick(pl[8]), .sequence_end(pl[9]),
      .cal_dac0_load(pl[2]), .cal_dac1_load(pl[3]), .serial_memory_select(sel),
      .serial_bit_out(sdo), .serial_memory_clock(sck), .cal_dac0_value(dac0),
      .cal_dac1_value(dac1), .conversion_allow(cav), .acquisition_start(ast),
      .acquisition_in_progress(aip), .config_mem_advance(adv), .scan_active(sact),
      .scan_sequence_go(sgo), .scan_clock_out(sco), .counter_cascade(casc),
      .counter5_enable(c5)
   );

   acr_eeprom_model u_mem (
      .serial_memory_select(sel), .serial_bit_out(sdo), .serial_memory_clock(sck),
      .shift_q(ee_q), .bit_cnt(ee_cnt)
   );

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d, errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // one write then an idle cycle, so each value is settled before the next
   task automatic wr(input logic [4:0] a, input logic wd, input logic [15:0] d);
      @(negedge clk_sys);
      io_addr = a;
      io_word = wd;
      io_wdata = d;
      io_write = 1'b1;
      @(negedge clk_sys);
      io_write = 1'b0;
      @(negedge clk_sys);
   endtask

   task automatic setw(input logic [15:0] w);
      wr(5'h00, 1'b1, w);
      @(negedge clk_sys);
   endtask

   task automatic chk_cfg(input logic [15:0] w);
      chk(sel, w[15]);
      chk(sdo, w[14]);
      chk(sck, w[13] & w[15]);
      chk(cav, !w[10]);
      chk(sact, w[7] & w[8]);
      chk(casc, w[5]);
      chk(c5, w[5]);
   endtask

   task automatic pulse(input int k);
      @(negedge clk_sys);
      pl[k] = 1'b1;
      @(negedge clk_sys);
      pl[k] = 1'b0;
      repeat (2) @(negedge clk_sys);
   endtask

   // pulse input k (10 is a falling external trigger), count highs on obs[o]
   task automatic fire(input int k, input int o, input int exp);
      int n;
      n = 0;
      @(negedge clk_sys);
      if (k == 10)
         external_trigger_n = 1'b0;
      else
         pl[k] = 1'b1;
      repeat (5)
      begin
         @(negedge clk_sys);
         pl = 10'h000;
         external_trigger_n = 1'b1;
         if (obs[o] === 1'b1)
            n++;
      end
      chk(n, exp);
   endtask

   task automatic shift8(input logic s, input logic [7:0] v);
      for (int i = 7; i >= 0; i--)
      begin
         setw({s, v[i], 14'h0000});
         setw({s, v[i], 14'h2000});
      end
   endtask

   initial
   begin
      logic [15:0] w;
      logic [7:0] b;
      logic [7:0] b2;
      logic [7:0] d0;
      int c;
      // the word is written while reset is held, since reset never defines it
      setw(16'h0000);
      reset = 1'b0;
      for (int i = 0; i < 12; i++)
      begin
         seed = xs(seed);
         w = seed[15:0] & acr_pkg::ACR_WRITE_MASK;
         setw(w);
         chk_cfg(w);
         wr(5'h02, 1'b1, ~w);
         wr(5'h00, 1'b0, ~w);
         @(negedge clk_sys);
         chk_cfg(w);
      end
      reset = 1'b1;
      repeat (2) @(negedge clk_sys);
      reset = 1'b0;
      repeat (3) @(negedge clk_sys);
      chk_cfg(w);
      // a long conversion run asks for the cascaded count
      setw(16'h0020);
      chk_cfg(16'h0020);
      // a lone clock pulse readies the memory before it is selected
      setw(16'h0000);
      setw(16'h2000);
      setw(16'h0000);
      c = ee_cnt;
      seed = xs(seed);
      b = seed[7:0];
      b2 = ~b;
      d0 = dac0;
      shift8(1'b1, b);
      chk(dac0, d0);
      chk(ee_q, b);
      chk(ee_cnt - c, 8);
      setw(16'h0000);
      pulse(2);
      chk(dac0, b);
      c = ee_cnt;
      shift8(1'b0, b2);
      chk(ee_cnt - c, 0);
      pulse(3);
      chk(dac1, b2);
      chk(dac0, b);
      setw(16'h0100);
      fire(4, 0, 1);
      chk(aip, 1'b1);
      fire(4, 0, 0);
      pulse(0);
      fire(10, 0, 1);
      pulse(0);
      setw(16'h0000);
      fire(4, 0, 0);
      fire(10, 0, 0);
      setw(16'h0300);
      fire(4, 0, 0);
      pulse(1);
      chk(aip, 1'b0);
      fire(4, 0, 1);
      pulse(0);
      fire(4, 0, 0);
      pulse(1);
      setw(16'h0110);
      fire(4, 0, 0);
      fire(10, 0, 0);
      fire(5, 0, 1);
      pulse(0);
      setw(16'h0180);
      fire(6, 3, 1);
      fire(6, 2, 1);
      fire(7, 2, 0);
      fire(9, 1, 1);
      setw(16'h1180);
      fire(7, 2, 1);
      fire(6, 2, 0);
      setw(16'h01c0);
      pulse(9);
      fire(8, 1, 1);
      fire(8, 1, 0);
      pulse(9);
      fire(8, 1, 1);
      setw(16'h0100);
      fire(6, 3, 0);
      results();
   end

   // the sequence needs well under ten thousand cycles
   initial
   begin
      #200000;
      error_cnt++;
      results();
   end
endmodule
